// ---- src/mcb_defines.vh ----
// Constants for the configuration, calendar and command register bank
`ifndef MCB_DEFINES_VH
`define MCB_DEFINES_VH

// Holding register addresses
`define MCB_REG_CFG_ADDR   16'h9cb8
`define MCB_REG_CFG_BAUD   16'h9cb9
`define MCB_REG_LOG_SIX    16'h9cc1
`define MCB_REG_LOG_SEVEN  16'h9cc2
`define MCB_REG_LOG_EIGHT  16'h9cc3
`define MCB_REG_CAL_YEAR   16'ha029
`define MCB_REG_CAL_MONTH  16'ha02a
`define MCB_REG_CAL_DAY    16'ha02b
`define MCB_REG_CAL_HOUR   16'ha02c
`define MCB_REG_CAL_MINUTE 16'ha02d
`define MCB_REG_CAL_SECOND 16'ha02e
`define MCB_REG_ACT_CODE   16'ha411
`define MCB_REG_ACT_OP_ONE 16'ha412
`define MCB_REG_ACT_OP_TWO 16'ha413

// Reset values
`define MCB_RST_CFG_ADDR   16'h0100
`define MCB_RST_CFG_BAUD   16'h0003
`define MCB_RST_LOG        16'h0000
`define MCB_RST_YEAR       16'h07d0
`define MCB_RST_MONTH      16'h0001
`define MCB_RST_DAY        16'h0001
`define MCB_RST_ZERO       16'h0000

// Action codes
`define MCB_ACT_RESTART    16'h0001
`define MCB_ACT_SAVE       16'h0002
`define MCB_ACT_FACTORY    16'h0003

// Field layout: bus address in the upper byte of the address word
`define MCB_ADDR_MSB       15
`define MCB_ADDR_LSB       8
`define MCB_BAUD_W         3

// Switch bank layout
`define MCB_DIP_W          9
`define MCB_DIP_ADDR_LSB   0
`define MCB_DIP_ADDR_W     6
`define MCB_DIP_BAUD_LSB   6
`define MCB_DIP_ADDR_MAX   6'h3e

// Timing
`define MCB_CLK_HZ         100000000
`define MCB_TICK_MS        1000
`define MCB_BLINK_MS       250
`define MCB_HOLD_MS        50
`define MCB_TICK_CYC       ((`MCB_CLK_HZ / 1000) * `MCB_TICK_MS)
`define MCB_BLINK_CYC      ((`MCB_CLK_HZ / 1000) * `MCB_BLINK_MS)
`define MCB_HOLD_CYC       ((`MCB_CLK_HZ / 1000) * `MCB_HOLD_MS)

`endif

// ---- src/mcb_calendar.v ----
// Calendar counter advanced by a one-second enable, with per-field load
`timescale 1ns/1ns
`include "mcb_defines.vh"

module mcb_calendar #(
  parameter TICK_CYC = `MCB_TICK_CYC
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Field load
  input  wire [5:0]  wr_en_i,
  input  wire [15:0] wdata_i,
  // Calendar fields
  output reg  [15:0] year_ff,
  output reg  [15:0] month_ff,
  output reg  [15:0] day_ff,
  output reg  [15:0] hour_ff,
  output reg  [15:0] minute_ff,
  output reg  [15:0] second_ff
);

  localparam CW = $clog2(TICK_CYC + 1);

  reg  [CW-1:0] tick_cnt_ff;
  wire          tick;
  reg  [15:0]   nxt_year;
  reg  [15:0]   nxt_month;
  reg  [15:0]   nxt_day;
  reg  [15:0]   nxt_hour;
  reg  [15:0]   nxt_minute;
  reg  [15:0]   nxt_second;

  function [15:0] days_in_month;
    input [15:0] yr;
    input [15:0] mo;
    begin
      case (mo)
        16'h0004, 16'h0006, 16'h0009, 16'h000b: days_in_month = 16'h001e;
        16'h0002: days_in_month = (yr[1:0] == 2'h0) ? 16'h001d : 16'h001c;
        default:  days_in_month = 16'h001f;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign tick = (tick_cnt_ff == TICK_CYC[CW-1:0] - 1'b1);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_ff <= {CW{1'b0}};
    end else if (tick) begin
      tick_cnt_ff <= {CW{1'b0}};
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carry chain second -> year
  always @* begin
    nxt_year   = year_ff;
    nxt_month  = month_ff;
    nxt_day    = day_ff;
    nxt_hour   = hour_ff;
    nxt_minute = minute_ff;
    nxt_second = second_ff;
    if (tick) begin
      nxt_second = second_ff + 16'h0001;
      if (second_ff >= 16'h003b) begin
        nxt_second = 16'h0000;
        nxt_minute = minute_ff + 16'h0001;
        if (minute_ff >= 16'h003b) begin
          nxt_minute = 16'h0000;
          nxt_hour   = hour_ff + 16'h0001;
          if (hour_ff >= 16'h0017) begin
            nxt_hour = 16'h0000;
            nxt_day  = day_ff + 16'h0001;
            if (day_ff >= days_in_month(year_ff, month_ff)) begin
              nxt_day   = 16'h0001;
              nxt_month = month_ff + 16'h0001;
              if (month_ff >= 16'h000c) begin
                nxt_month = 16'h0001;
                nxt_year  = year_ff + 16'h0001;
              end
            end
          end
        end
      end
    end
    // A bus write to a field takes precedence over the carry into it
    if (wr_en_i[0]) nxt_year   = wdata_i;
    if (wr_en_i[1]) nxt_month  = wdata_i;
    if (wr_en_i[2]) nxt_day    = wdata_i;
    if (wr_en_i[3]) nxt_hour   = wdata_i;
    if (wr_en_i[4]) nxt_minute = wdata_i;
    if (wr_en_i[5]) nxt_second = wdata_i;
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      year_ff   <= `MCB_RST_YEAR;
      month_ff  <= `MCB_RST_MONTH;
      day_ff    <= `MCB_RST_DAY;
      hour_ff   <= `MCB_RST_ZERO;
      minute_ff <= `MCB_RST_ZERO;
      second_ff <= `MCB_RST_ZERO;
    end else begin
      year_ff   <= nxt_year;
      month_ff  <= nxt_month;
      day_ff    <= nxt_day;
      hour_ff   <= nxt_hour;
      minute_ff <= nxt_minute;
      second_ff <= nxt_second;
    end
  end

endmodule // mcb_calendar

// ---- src/mcb_bank.v ----
// Configuration, calendar and command holding-register bank with panel logic
//
// Functional notes
// - Three log-name words are 16-bit read/write registers that reset to zero.
// - Writing 1, 2 or 3 to the action code restarts, saves or restores factory settings.
// - With every switch at zero the bus address and baud code come from stored settings.
// - With any switch set the bus address and baud code come from the switches.
// - A pen drive with an update file present at power-up starts a firmware update.
// - The firmware update leaves the working configuration registers untouched.
// - The fault indicator blinks while a firmware update runs.
// - Outside a firmware update the fault indicator is lit while any fault input is active.
// - The receive and transmit indicators blink while traffic is seen on the link.
// - The switched-output indicator follows the digital output.
// - Every configuration word is readable and writable through the register port.
// - Baud codes 0 to 7 map to 1200 through 115200 bit/s with code 3 as default.
`timescale 1ns/1ns
`include "mcb_defines.vh"

module mcb_bank #(
  parameter TICK_CYC  = `MCB_TICK_CYC,
  parameter BLINK_CYC = `MCB_BLINK_CYC,
  parameter HOLD_CYC  = `MCB_HOLD_CYC,
  parameter FAULT_W   = 4
) (
  // Clock and reset
  input  wire                 core_clk_i,
  input  wire                 rstn_i,
  // Register port
  input  wire                 reg_req_i,
  input  wire                 reg_we_i,
  input  wire [15:0]          reg_addr_i,
  input  wire [15:0]          reg_wdata_i,
  output wire                 reg_ack_o,
  output wire                 reg_err_o,
  output wire [15:0]          reg_rdata_o,
  // Stored settings
  input  wire                 nvm_load_i,
  input  wire [15:0]          nvm_addr_word_i,
  input  wire [15:0]          nvm_baud_i,
  output wire                 save_cfg_o,
  output wire                 restart_o,
  output wire                 factory_o,
  output wire [15:0]          act_op_one_o,
  output wire [15:0]          act_op_two_o,
  // Front-panel switches and effective link settings
  input  wire [`MCB_DIP_W-1:0] dip_i,
  output wire [7:0]           bus_addr_o,
  output wire [2:0]           baud_code_o,
  output wire [16:0]          baud_rate_o,
  // Firmware update
  input  wire                 usb_present_i,
  input  wire                 usb_file_i,
  input  wire                 fw_done_i,
  output wire                 fw_update_o,
  // Indicators
  input  wire [FAULT_W-1:0]   fault_i,
  input  wire                 rx_act_i,
  input  wire                 tx_act_i,
  input  wire                 dout_i,
  output wire                 fault_led_o,
  output wire                 rx_led_o,
  output wire                 tx_led_o,
  output wire                 dout_led_o
);

  localparam BW = $clog2(BLINK_CYC + 1);
  localparam HW = $clog2(HOLD_CYC + 1);
  localparam SW = `MCB_DIP_W + 2;

  localparam ST_SETTLE = 2'h0;
  localparam ST_UPDATE = 2'h1;
  localparam ST_RUN    = 2'h2;

  reg  [1:0]           rst_sync_ff;
  wire                 rst_n;

  reg  [SW-1:0]        pin_s1_ff;
  reg  [SW-1:0]        pin_s2_ff;
  reg  [SW-1:0]        pin_s3_ff;
  reg  [SW-1:0]        pin_ff;

  reg  [15:0]          cfg_addr_ff;
  reg  [15:0]          cfg_baud_ff;
  reg  [15:0]          log_word_ff [0:2];
  reg  [15:0]          act_code_ff;
  reg  [15:0]          act_op_one_ff;
  reg  [15:0]          act_op_two_ff;
  reg                  save_ff;
  reg                  restart_ff;
  reg                  factory_ff;

  reg                  ack_ff;
  reg                  err_ff;
  reg  [15:0]          rdata_ff;
  reg  [15:0]          nxt_rdata;

  reg  [1:0]           st_ff;
  reg  [2:0]           settle_ff;
  reg  [BW-1:0]        blink_cnt_ff;
  reg                  blink_ff;
  reg                  fault_led_ff;
  reg                  dout_led_ff;

  wire [15:0]          cal_year;
  wire [15:0]          cal_month;
  wire [15:0]          cal_day;
  wire [15:0]          cal_hour;
  wire [15:0]          cal_minute;
  wire [15:0]          cal_second;

  wire                 wr;
  wire [3:0]           wr_idx;
  wire [3:0]           rd_idx;
  wire [5:0]           cal_wr;
  wire [`MCB_DIP_W-1:0] dip;
  wire                 dip_any;
  wire [5:0]           dip_addr;
  wire [1:0]           act_in;
  wire [1:0]           led_on;

  function [3:0] reg_index;
    input [15:0] a;
    begin
      case (a)
        `MCB_REG_CFG_ADDR:   reg_index = 4'h1;
        `MCB_REG_CFG_BAUD:   reg_index = 4'h2;
        `MCB_REG_LOG_SIX:    reg_index = 4'h3;
        `MCB_REG_LOG_SEVEN:  reg_index = 4'h4;
        `MCB_REG_LOG_EIGHT:  reg_index = 4'h5;
        `MCB_REG_CAL_YEAR:   reg_index = 4'h6;
        `MCB_REG_CAL_MONTH:  reg_index = 4'h7;
        `MCB_REG_CAL_DAY:    reg_index = 4'h8;
        `MCB_REG_CAL_HOUR:   reg_index = 4'h9;
        `MCB_REG_CAL_MINUTE: reg_index = 4'ha;
        `MCB_REG_CAL_SECOND: reg_index = 4'hb;
        `MCB_REG_ACT_CODE:   reg_index = 4'hc;
        `MCB_REG_ACT_OP_ONE: reg_index = 4'hd;
        `MCB_REG_ACT_OP_TWO: reg_index = 4'he;
        default:             reg_index = 4'h0;
      endcase
    end
  endfunction

  function [16:0] baud_of_code;
    input [2:0] c;
    begin
      case (c)
        3'h0:    baud_of_code = 17'h004b0;
        3'h1:    baud_of_code = 17'h00960;
        3'h2:    baud_of_code = 17'h012c0;
        3'h3:    baud_of_code = 17'h02580;
        3'h4:    baud_of_code = 17'h04b00;
        3'h5:    baud_of_code = 17'h09600;
        3'h6:    baud_of_code = 17'h0e100;
        default: baud_of_code = 17'h1c200;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= {SW{1'b0}};
      pin_s2_ff <= {SW{1'b0}};
      pin_s3_ff <= {SW{1'b0}};
      pin_ff    <= {SW{1'b0}};
    end else begin
      pin_s1_ff <= {usb_file_i, usb_present_i, dip_i};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff    <= (pin_s2_ff & pin_s3_ff) | (pin_ff & (pin_s2_ff | pin_s3_ff));
    end
  end
  assign dip = pin_ff[`MCB_DIP_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode
  assign wr     = reg_req_i & reg_we_i;
  assign wr_idx = wr ? reg_index(reg_addr_i) : 4'h0;
  assign rd_idx = reg_index(reg_addr_i);
  assign cal_wr = {wr_idx == 4'hb, wr_idx == 4'ha, wr_idx == 4'h9,
                   wr_idx == 4'h8, wr_idx == 4'h7, wr_idx == 4'h6};

  always @* begin
    case (rd_idx)
      4'h1:    nxt_rdata = cfg_addr_ff;
      4'h2:    nxt_rdata = cfg_baud_ff;
      4'h3:    nxt_rdata = log_word_ff[0];
      4'h4:    nxt_rdata = log_word_ff[1];
      4'h5:    nxt_rdata = log_word_ff[2];
      4'h6:    nxt_rdata = cal_year;
      4'h7:    nxt_rdata = cal_month;
      4'h8:    nxt_rdata = cal_day;
      4'h9:    nxt_rdata = cal_hour;
      4'ha:    nxt_rdata = cal_minute;
      4'hb:    nxt_rdata = cal_second;
      4'hc:    nxt_rdata = act_code_ff;
      4'hd:    nxt_rdata = act_op_one_ff;
      4'he:    nxt_rdata = act_op_two_ff;
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      ack_ff   <= reg_req_i;
      err_ff   <= reg_req_i & (rd_idx == 4'h0);
      if (reg_req_i & ~reg_we_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working configuration and log name; only bus, stored load and factory
  // restore touch these, never the firmware update path
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_addr_ff    <= `MCB_RST_CFG_ADDR;
      cfg_baud_ff    <= `MCB_RST_CFG_BAUD;
      log_word_ff[0] <= `MCB_RST_LOG;
      log_word_ff[1] <= `MCB_RST_LOG;
      log_word_ff[2] <= `MCB_RST_LOG;
    end else if (factory_ff) begin
      cfg_addr_ff    <= `MCB_RST_CFG_ADDR;
      cfg_baud_ff    <= `MCB_RST_CFG_BAUD;
      log_word_ff[0] <= `MCB_RST_LOG;
      log_word_ff[1] <= `MCB_RST_LOG;
      log_word_ff[2] <= `MCB_RST_LOG;
    end else if (nvm_load_i) begin
      cfg_addr_ff <= nvm_addr_word_i;
      cfg_baud_ff <= nvm_baud_i;
    end else begin
      if (wr_idx == 4'h1) cfg_addr_ff    <= reg_wdata_i;
      if (wr_idx == 4'h2) cfg_baud_ff    <= reg_wdata_i;
      if (wr_idx == 4'h3) log_word_ff[0] <= reg_wdata_i;
      if (wr_idx == 4'h4) log_word_ff[1] <= reg_wdata_i;
      if (wr_idx == 4'h5) log_word_ff[2] <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Action code and operands; one pulse per write of the code
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      act_code_ff   <= 16'h0000;
      act_op_one_ff <= 16'h0000;
      act_op_two_ff <= 16'h0000;
      save_ff       <= 1'b0;
      restart_ff    <= 1'b0;
      factory_ff    <= 1'b0;
    end else begin
      if (wr_idx == 4'hd) act_op_one_ff <= reg_wdata_i;
      if (wr_idx == 4'he) act_op_two_ff <= reg_wdata_i;
      if (wr_idx == 4'hc) act_code_ff   <= reg_wdata_i;
      restart_ff <= (wr_idx == 4'hc) & (reg_wdata_i == `MCB_ACT_RESTART);
      save_ff    <= (wr_idx == 4'hc) & (reg_wdata_i == `MCB_ACT_SAVE);
      factory_ff <= (wr_idx == 4'hc) & (reg_wdata_i == `MCB_ACT_FACTORY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calendar
  mcb_calendar #(
    .TICK_CYC (TICK_CYC)
  ) mcb_calendar_inst (
    .clk_i     (core_clk_i),
    .rst_n_i   (rst_n),
    .wr_en_i   (cal_wr),
    .wdata_i   (reg_wdata_i),
    .year_ff   (cal_year),
    .month_ff  (cal_month),
    .day_ff    (cal_day),
    .hour_ff   (cal_hour),
    .minute_ff (cal_minute),
    .second_ff (cal_second)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Effective link settings: switches override stored settings
  assign dip_any  = |dip;
  assign dip_addr = (dip[`MCB_DIP_ADDR_LSB +: `MCB_DIP_ADDR_W] > `MCB_DIP_ADDR_MAX) ?
                    `MCB_DIP_ADDR_MAX : dip[`MCB_DIP_ADDR_LSB +: `MCB_DIP_ADDR_W];
  assign bus_addr_o  = dip_any ? {2'h0, dip_addr} :
                       cfg_addr_ff[`MCB_ADDR_MSB:`MCB_ADDR_LSB];
  assign baud_code_o = dip_any ? dip[`MCB_DIP_BAUD_LSB +: `MCB_BAUD_W] :
                       cfg_baud_ff[`MCB_BAUD_W-1:0];
  assign baud_rate_o = baud_of_code(baud_code_o);

  ////////////////////////////////////////////////////////////////////////////
  // Power-up update check, taken once the synchronisers have settled
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff     <= ST_SETTLE;
      settle_ff <= 3'h0;
    end else begin
      case (st_ff)
        ST_SETTLE: begin
          // Wait long enough for pin_ff to hold the pins sampled after reset
          settle_ff <= settle_ff + 3'h1;
          if (settle_ff == 3'h7) begin
            st_ff <= (pin_ff[SW-1] & pin_ff[SW-2]) ? ST_UPDATE : ST_RUN;
          end
        end
        ST_UPDATE: begin
          if (fw_done_i) begin
            st_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          st_ff <= ST_RUN;
        end
        default: begin
          st_ff <= ST_RUN;
        end
      endcase
    end
  end
  assign fw_update_o = (st_ff == ST_UPDATE);

  ////////////////////////////////////////////////////////////////////////////
  // Blink phase
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_ff <= {BW{1'b0}};
      blink_ff     <= 1'b0;
    end else if (blink_cnt_ff == BLINK_CYC[BW-1:0] - 1'b1) begin
      blink_cnt_ff <= {BW{1'b0}};
      blink_ff     <= ~blink_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Traffic indicators: held for a while after each activity pulse, blinking
  assign act_in = {tx_act_i, rx_act_i};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_act
      reg [HW-1:0] hold_ff;
      reg          led_ff;
      always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          hold_ff <= {HW{1'b0}};
          led_ff  <= 1'b0;
        end else begin
          if (act_in[g]) begin
            hold_ff <= HOLD_CYC[HW-1:0];
          end else if (hold_ff != {HW{1'b0}}) begin
            hold_ff <= hold_ff - 1'b1;
          end
          led_ff <= (hold_ff != {HW{1'b0}}) & blink_ff;
        end
      end
      assign led_on[g] = led_ff;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Fault and output indicators
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fault_led_ff <= 1'b0;
      dout_led_ff  <= 1'b0;
    end else begin
      fault_led_ff <= (st_ff == ST_UPDATE) ? blink_ff :
                      (|fault_i);
      dout_led_ff  <= dout_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_ack_o    = ack_ff;
  assign reg_err_o    = err_ff;
  assign reg_rdata_o  = rdata_ff;
  assign save_cfg_o   = save_ff;
  assign restart_o    = restart_ff;
  assign factory_o    = factory_ff;
  assign act_op_one_o = act_op_one_ff;
  assign act_op_two_o = act_op_two_ff;
  assign fault_led_o  = fault_led_ff;
  assign rx_led_o     = led_on[0];
  assign tx_led_o     = led_on[1];
  assign dout_led_o   = dout_led_ff;

endmodule // mcb_bank

// ---- tb/mcb_bank_asserts.sv ----
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
module mcb_bank_asserts #(
  parameter BLINK_CYC = 4
) (
  input wire        core_clk_i,
  input wire        rstn_i,
  input wire        reg_req_i,
  input wire        reg_we_i,
  input wire [15:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire        reg_ack_o,
  input wire        reg_err_o,
  input wire [15:0] reg_rdata_o,
  input wire        restart_o,
  input wire        save_cfg_o,
  input wire        factory_o,
  input wire [2:0]  baud_code_o,
  input wire [16:0] baud_rate_o,
  input wire        fw_update_o,
  input wire [3:0]  fault_i,
  input wire        fault_led_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  localparam int RATE [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  wire       act_wr = reg_req_i && reg_we_i && reg_addr_i == 16'ha411;
  reg  [7:0] same_ff;
  // Cycles the fault lamp has stood still during an update
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      same_ff <= 8'h00;
    else if (fw_update_o && fault_led_o == $past(fault_led_o))
      same_ff <= same_ff + 8'h01;
    else
      same_ff <= 8'h00;
  end
  ////////////////////////////////////////
  a_ack_follows: assert property (reg_req_i |=> reg_ack_o)
    else $error("ack missing after request");
  a_err_with_ack: assert property (reg_err_o |-> reg_ack_o)
    else $error("err without ack");
  a_rdata_hold: assert property (!(reg_req_i && !reg_we_i) |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_restart_once: assert property (restart_o == $past(act_wr && reg_wdata_i == 16'h0001))
    else $error("restart pulse wrong");
  a_save_once: assert property (save_cfg_o == $past(act_wr && reg_wdata_i == 16'h0002))
    else $error("save pulse wrong");
  a_factory_once: assert property (factory_o == $past(act_wr && reg_wdata_i == 16'h0003))
    else $error("factory pulse wrong");
  a_baud_map: assert property (baud_rate_o == RATE[baud_code_o])
    else $error("baud rate does not match code");
  a_fault_lamp: assert property (!fw_update_o && !$past(fw_update_o) |->
    fault_led_o == |$past(fault_i)) else $error("fault lamp wrong");
  // Lamp lags the phase by a cycle, so the first run may be one longer
  a_update_blink: assert property (same_ff <= BLINK_CYC + 1)
    else $error("fault lamp not blinking during update");
  cover property (factory_o);
  cover property (reg_err_o);
  cover property (fw_update_o ##1 !fw_update_o);
endmodule // mcb_bank_asserts

// ---- tb/mcb_master.sv ----
// Register-port master standing in for the serial bus master
`timescale 1ns/1ns
module mcb_master (
  // Clock
  input  wire        clk_i,
  // Register port
  output reg         req_o,
  output reg         we_o,
  output reg  [15:0] addr_o,
  output reg  [15:0] wdata_o,
  input  wire        ack_i,
  input  wire        err_i,
  input  wire [15:0] rdata_i
);
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
  end
  task access(input bit w, input [15:0] a, input [15:0] d,
              output [15:0] rd, output bit er, output bit ok);
    int i;
    @(posedge clk_i);
    req_o <= 1'b1;
    we_o <= w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    // Released address and data lines show the inverse rather than a stale value
    req_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    ok = 0;
    for (i = 0; i < 4 && !ok; i++) begin
      @(posedge clk_i);
      ok = (ack_i === 1'b1);
    end
    rd = rdata_i;
    er = (err_i === 1'b1);
  endtask
endmodule // mcb_master

// ---- tb/mcb_bank_tb.sv ----
// Self-checking bench for the register bank
`timescale 1ns/1ns
module mcb_bank_tb;
  reg         core_clk_i, rstn_i, nvm_load_i, usb_i, fw_done_i, rx_i, tx_i, dout_i;
  reg  [15:0] nvm_addr, nvm_baud, rd;
  reg  [8:0]  dip_i;
  reg  [3:0]  fault_i, f_prev;
  reg  [2:0]  act_seen;
  reg  [31:0] seed;
  wire        req, we, ack, err, restart, save, factory, fw_upd, f_led, rx_led, tx_led, d_led;
  wire [15:0] addr, wdata, rdata, op_one, op_two;
  wire [7:0]  bus_addr;
  wire [2:0]  baud_code;
  wire [16:0] baud_rate;
  int         err_total, n_compared, cyc, model [int];
  bit         er, ok;
  bit  [15:0] regs [5] = '{16'h9cc1, 16'h9cc2, 16'h9cc3, 16'ha412, 16'ha413};
  mcb_bank #(.TICK_CYC(20), .BLINK_CYC(4), .HOLD_CYC(16)) mcb_bank_inst (
    .core_clk_i, .rstn_i, .reg_req_i(req), .reg_we_i(we), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_ack_o(ack), .reg_err_o(err), .reg_rdata_o(rdata),
    .nvm_load_i, .nvm_addr_word_i(nvm_addr), .nvm_baud_i(nvm_baud), .save_cfg_o(save),
    .restart_o(restart), .factory_o(factory), .act_op_one_o(op_one), .act_op_two_o(op_two),
    .dip_i, .bus_addr_o(bus_addr), .baud_code_o(baud_code), .baud_rate_o(baud_rate),
    .usb_present_i(usb_i), .usb_file_i(usb_i), .fw_done_i, .fw_update_o(fw_upd),
    .fault_i, .rx_act_i(rx_i), .tx_act_i(tx_i), .dout_i, .fault_led_o(f_led),
    .rx_led_o(rx_led), .tx_led_o(tx_led), .dout_led_o(d_led));
  mcb_master mcb_master_inst (.clk_i(core_clk_i), .req_o(req), .we_o(we), .addr_o(addr),
    .wdata_o(wdata), .ack_i(ack), .err_i(err), .rdata_i(rdata));
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string what, input [31:0] exp, input [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task rw(input bit w, input [15:0] a, input [15:0] d);
    mcb_master_inst.access(w, a, d, rd, er, ok);
    chk("ack", 1, ok);
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (restart || save || factory) act_seen <= {factory, save, restart};
    if (cyc == 5000) begin
      err_total++;
      end_of_test;
    end
  end
  ////////////////////////////////////////
  initial begin
    {rstn_i, nvm_load_i, fw_done_i, rx_i, tx_i, dout_i, fault_i, f_prev} = 0;
    {nvm_addr, nvm_baud, dip_i, act_seen, cyc} = 0;
    usb_i = 1'b1;
    seed = 32'h12947b3b;
    repeat (12) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    ok = 0;
    for (int i = 0; i < 40 && !ok; i++) begin
      tick(1);
      ok = (fw_upd === 1'b1);
    end
    chk("fw_update", 1, ok);
    rw(0, 16'h9cb9, 0);
    chk("baud_word", 3, rd);
    tick(12);
    @(posedge core_clk_i) fw_done_i <= 1'b1;
    @(posedge core_clk_i) fw_done_i <= 1'b0;
    tick(2);
    chk("fw_end", 0, fw_upd);
    rw(0, 16'ha029, 0);
    chk("year", 16'h07d0, rd);
    foreach (regs[i]) begin
      rw(0, regs[i], 0);
      chk("reset_val", 0, rd);
      seed = lfsr(seed);
      model[regs[i]] = seed[15:0];
      rw(1, regs[i], seed[15:0]);
    end
    foreach (regs[i]) begin
      rw(0, regs[i], 0);
      chk("rdata", model[regs[i]], rd);
    end
    chk("op_one", model[16'ha412], op_one);
    chk("op_two", model[16'ha413], op_two);
    rw(0, 16'h9cc4, 0);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rd);
    for (int c = 1; c <= 3; c++) begin
      rw(1, 16'ha411, c[15:0]);
      tick(1);
      chk("action", 32'd1 << (c - 1), act_seen);
    end
    rw(0, 16'h9cc1, 0);
    chk("log_factory", 0, rd);
    @(posedge core_clk_i) {nvm_addr, nvm_baud, nvm_load_i} <= {16'h5000, 16'h0007, 1'b1};
    @(posedge core_clk_i) nvm_load_i <= 1'b0;
    tick(2);
    chk("nvm_addr", 8'h50, bus_addr);
    chk("nvm_rate", 115200, baud_rate);
    rw(1, 16'h9cb9, 16'h0001);
    tick(1);
    chk("reg_rate", 2400, baud_rate);
    @(posedge core_clk_i) dip_i <= {3'd5, 6'd63};
    tick(8);
    chk("dip_addr", 62, bus_addr);
    chk("dip_code", 5, baud_code);
    @(posedge core_clk_i) dip_i <= 9'h000;
    tick(8);
    chk("back_addr", 8'h50, bus_addr);
    rw(1, 16'ha02d, 16'd5);
    rw(1, 16'ha02e, 16'd59);
    tick(25);
    rw(0, 16'ha02d, 0);
    chk("minute", 6, rd);
    @(posedge core_clk_i) {rx_i, tx_i} <= 2'b11;
    @(posedge core_clk_i) {rx_i, tx_i} <= 2'b00;
    ok = 0;
    repeat (10) begin
      tick(1);
      ok = ok | ((rx_led & tx_led) === 1'b1);
    end
    chk("rx_tx_blink", 1, ok);
    tick(30);
    chk("rx_idle", 0, rx_led);
    repeat (20) begin
      @(posedge core_clk_i);
      seed = lfsr(seed);
      {dout_i, fault_i} <= seed[4:0];
      #1;
      chk("fault_led", |f_prev, f_led);
      f_prev = fault_i;
      tick(1);
      chk("dout_led", dout_i, d_led);
    end
    end_of_test;
  end
endmodule // mcb_bank_tb
bind mcb_bank mcb_bank_asserts #(.BLINK_CYC(BLINK_CYC)) mcb_bank_asserts_inst (
  .core_clk_i, .rstn_i, .reg_req_i, .reg_we_i, .reg_addr_i, .reg_wdata_i, .reg_ack_o,
  .reg_err_o, .reg_rdata_o, .restart_o, .save_cfg_o, .factory_o, .baud_code_o,
  .baud_rate_o, .fw_update_o, .fault_i, .fault_led_o);
